/* rtl/cpd_pkg.sv */
`default_nettype none
package cpd_pkg;
  // ****************************************************
  // Widths and counts
  // ****************************************************
  localparam int DW = 16;
  localparam int IW = 24;
  localparam int PCW = 23;
  localparam int NREG = 16;
  localparam int NIRQ = 118;
  localparam int NTRAP = 8;
  localparam int IDW = 7;
  localparam int PRW = 3;
  localparam logic [3:0] SP_IDX = 4'hF;
  // ****************************************************
  // Instruction field positions
  // ****************************************************
  localparam int F_OP = 20;
  localparam int F_RX = 16;
  localparam int F_RD = 8;
  localparam int F_RS = 4;
  localparam int F_RT = 0;
  localparam int F_SGN = 19;
  localparam int F_LONG = 18;
  localparam int F_BYTE = 19;
  localparam int F_MODE = 17;
  localparam int F_RCNT_W = 14;
  localparam int HI_PRIO = 13;
  // ****************************************************
  // Addresses and timing
  // ****************************************************
  localparam logic [PCW-1:0] RESET_VEC = 23'h000000;
  localparam logic [PCW-1:0] IVT_BASE = 23'h000004;
  localparam logic [DW-1:0] WREG_TOP = 16'h0020;
  localparam logic [DW-1:0] SR_ADDR = 16'h0042;
  localparam logic [DW-1:0] SP_STEP = 16'h0002;
  localparam int EXT_BIT = 15;
  localparam logic [4:0] DIV_STEP_LAST = 5'h10;
  localparam logic [4:0] DIV_FIX = 5'h11;
  localparam logic [4:0] DIV_LAST = 5'h12;
  localparam logic [PRW-1:0] TRAP_PRIO = 3'h7;
  // ****************************************************
  // Opcodes and sub-operations
  // ****************************************************
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_ALU = 4'h1;
  localparam logic [3:0] OP_LIT = 4'h2;
  localparam logic [3:0] OP_LD = 4'h3;
  localparam logic [3:0] OP_ST = 4'h4;
  localparam logic [3:0] OP_TRI = 4'h5;
  localparam logic [3:0] OP_MUL = 4'h6;
  localparam logic [3:0] OP_DIV = 4'h7;
  localparam logic [3:0] OP_REP = 4'h8;
  localparam logic [3:0] OP_BRA = 4'h9;
  localparam logic [3:0] OP_CALL = 4'hA;
  localparam logic [3:0] OP_RET = 4'hB;
  localparam logic [3:0] OP_RETI = 4'hC;
  localparam logic [3:0] OP_DMOV = 4'hD;
  localparam logic [3:0] OP_BZ = 4'hE;
  localparam logic [3:0] OP_LDD = 4'hF;
  localparam logic [3:0] ALU_ADD = 4'h0;
  localparam logic [3:0] ALU_SUB = 4'h1;
  localparam logic [3:0] ALU_AND = 4'h2;
  localparam logic [3:0] ALU_OR = 4'h3;
  localparam logic [1:0] MUL_UU = 2'h0;
  localparam logic [1:0] MUL_SS = 2'h1;
  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {ST_RUN, ST_PUSH, ST_POP} cpd_state_t;
  typedef struct packed {
    logic rd_en;
    logic [DW-1:0] rd_addr;
    logic rd_ext;
    logic wr_en;
    logic [DW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic wr_ext;
  } cpd_dm_req_t;
  typedef struct packed {
    logic valid;
    logic [IDW-1:0] id;
  } cpd_ack_t;
  typedef struct packed {
    logic hit;
    logic [IDW-1:0] id;
    logic [PRW-1:0] prio;
  } cpd_sel_t;
  typedef struct packed {
    cpd_state_t st;
    logic [PCW-1:0] ex_pc;
    logic ex_valid;
    logic [NREG-1:0][DW-1:0] w;
    logic [PRW-1:0] cpu_prio;
    logic [F_RCNT_W-1:0] rep_cnt;
    logic [PCW-1:0] rep_pc;
    logic rep_on;
    logic [4:0] dcnt;
    logic [DW:0] drem;
    logic [DW-1:0] dq;
    logic [DW-1:0] dd;
    logic dneg_q;
    logic dneg_r;
    logic ph;
    logic [PCW-1:0] tgt;
    logic [DW-1:0] hi;
    logic retfie;
    logic intr;
    logic [PRW-1:0] nprio;
    logic [IDW-1:0] aid;
    cpd_ack_t ack;
  } cpd_core_st_t;
endpackage
`default_nettype wire

/* rtl/cpd_core.sv */
`timescale 1ns/1ns
`default_nettype none
// Contract
// RQ1: 16-bit data, 24-bit instruction words
// RQ2: 23-bit program counter
// RQ3: next instruction prefetched one cycle ahead
// RQ4: single cycle except flow, double move, table
// RQ5: repeat loop without overhead, interruptible
// RQ6: sixteen 16-bit general working registers
// RQ7: last register is the stack pointer
// RQ8: upper half of data space is window
// RQ9: inherent, relative, literal, direct, indirect modes
// RQ10: read, register read, write per cycle
// RQ11: 17x17 multiplier, all signedness, two sizes; code has no unsigned x signed mode
// RQ12: every multiply takes one cycle
// RQ13: non-restoring divide, 32 or 16 by 16
// RQ14: divide takes 19 cycles, interruptible
// RQ15: vectored, 8 traps, 118 interrupt sources
// RQ16: each source has its own priority
// RQ17: core registers mapped into data space
// RQ18: priority code 111 highest, 000 disabled
module cpd_core
  import cpd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  output logic [PCW-1:0] o_pm_addr,
  input wire logic [IW-1:0] i_pm_data,
  output cpd_dm_req_t o_dm,
  input wire logic [DW-1:0] i_dm_rdata,
  input wire logic [NIRQ-1:0] i_irq_req,
  input wire logic [NIRQ*PRW-1:0] i_irq_prio,
  input wire logic [NTRAP-1:0] i_trap,
  output cpd_ack_t o_ack,
  output logic [PRW-1:0] o_cpu_prio,
  output logic [PCW-1:0] o_program_counter
);

  // ****************************************************
  // Functions
  // ****************************************************
  // Highest priority pending source, lowest index on ties
  function automatic cpd_sel_t pick_src(input logic [NIRQ-1:0] req,
      input logic [NIRQ*PRW-1:0] pr, input logic [NTRAP-1:0] trap,
      input logic [PRW-1:0] cur);
    cpd_sel_t s;
    logic [PRW-1:0] p;
    s = '0;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      p = pr[i*PRW +: PRW];
      if (req[i] && p > cur && (!s.hit || p >= s.prio)) begin // RQ16 RQ18
        s.hit = 1'b1;
        s.id = IDW'(i + NTRAP);
        s.prio = p;
      end
    end
    for (int i = NTRAP - 1; i >= 0; i--) begin
      if (trap[i]) begin // RQ15
        s.hit = 1'b1;
        s.id = IDW'(i);
        s.prio = TRAP_PRIO;
      end
    end
    return s;
  endfunction

  // Two-operand arithmetic and logic
  function automatic logic [DW-1:0] alu(input logic [3:0] sub,
      input logic [DW-1:0] a, input logic [DW-1:0] b);
    unique case (sub)
      ALU_ADD: return a + b;
      ALU_SUB: return a - b;
      ALU_AND: return a & b;
      ALU_OR: return a | b;
      default: return a ^ b;
    endcase
  endfunction

  // Extended 17x17 product, word or byte operands
  function automatic logic [2*DW-1:0] mul17(input logic [DW-1:0] a,
      input logic [DW-1:0] b, input logic [1:0] mode, input logic byt);
    logic [DW:0] x;
    logic [DW:0] y;
    logic sa;
    logic sb;
    logic signed [2*DW+1:0] pr;
    sa = (mode != MUL_UU);
    sb = (mode == MUL_SS);
    x = byt ? {{9{sa & a[7]}}, a[7:0]} : {sa & a[DW-1], a};
    y = byt ? {{9{sb & b[7]}}, b[7:0]} : {sb & b[DW-1], b};
    pr = $signed(x) * $signed(y);
    return pr[2*DW-1:0];
  endfunction

  // One non-restoring step: remainder, quotient in/out
  function automatic logic [2*DW:0] dstep(input logic [DW:0] rem,
      input logic [DW-1:0] q, input logic [DW-1:0] d);
    logic [DW+1:0] sh;
    logic [DW+1:0] nr;
    sh = {rem, q[DW-1]};
    nr = rem[DW] ? sh + {2'b00, d} : sh - {2'b00, d};
    return {nr[DW:0], q[DW-2:0], ~nr[DW]};
  endfunction

  // Addresses served by the core itself
  function automatic logic is_core(input logic [DW-1:0] a);
    return (a < WREG_TOP) || (a == SR_ADDR);
  endfunction

  // ****************************************************
  // State and decode
  // ****************************************************
  cpd_core_st_t q;
  cpd_core_st_t n;
  cpd_dm_req_t dm;
  cpd_sel_t sel;
  logic [PCW-1:0] pm_addr;
  logic [3:0] op;
  logic [3:0] rd;
  logic [3:0] rs;
  logic [3:0] rt;
  logic [3:0] rx;
  logic take;
  logic exec;
  logic hold;
  logic jump;
  logic [PCW-1:0] jt;
  logic [PCW-1:0] ret_pc;
  logic do_rd;
  logic do_wr;
  logic [DW-1:0] ma_rd;
  logic [DW-1:0] ma_wr;
  logic [DW-1:0] wdat;
  logic [DW-1:0] rdat;
  logic [DW-1:0] sp_dn;
  logic [2*DW-1:0] num;
  logic [2*DW-1:0] an;
  logic [DW-1:0] ad;
  logic nneg;
  logic dneg;

  assign op = i_pm_data[F_OP +: 4];
  assign rx = i_pm_data[F_RX +: 4];
  assign rd = i_pm_data[F_RD +: 4];
  assign rs = i_pm_data[F_RS +: 4];
  assign rt = i_pm_data[F_RT +: 4];
  assign sel = pick_src(i_irq_req, i_irq_prio, i_trap, q.cpu_prio);
  assign take = (q.st == ST_RUN) && q.ex_valid && sel.hit; // RQ14 RQ5
  assign exec = (q.st == ST_RUN) && q.ex_valid && !take;
  assign sp_dn = q.w[SP_IDX] - SP_STEP; // RQ7
  assign ret_pc = q.ex_pc + 23'h000001;

  // Read address: stack on pops, direct literal, else pointer
  always_comb begin
    if (q.st == ST_POP || (exec && (op == OP_RET || op == OP_RETI))) begin
      ma_rd = sp_dn;
    end else if (op == OP_LDD) begin
      ma_rd = i_pm_data[DW-1:0]; // RQ9
    end else begin
      ma_rd = q.w[rs];
    end
    if (ma_rd == SR_ADDR) begin
      rdat = {13'h0000, q.cpu_prio}; // RQ17
    end else if (ma_rd < WREG_TOP) begin
      rdat = q.w[ma_rd[4:1]]; // RQ17
    end else begin
      rdat = i_dm_rdata;
    end
  end

  // ****************************************************
  // Next-state logic
  // ****************************************************
  always_comb begin
    n = q;
    n.ack = '0;
    n.ex_valid = 1'b1;
    hold = 1'b0;
    jump = 1'b0;
    jt = q.ex_pc;
    do_rd = 1'b0;
    do_wr = 1'b0;
    ma_wr = q.w[rs];
    wdat = q.w[rt];
    pm_addr = q.ex_pc;
    num = '0;
    an = '0;
    ad = '0;
    nneg = 1'b0;
    dneg = 1'b0;
    unique case (q.st)
      ST_PUSH: begin
        // Second stacked word, then enter target
        do_wr = 1'b1;
        ma_wr = q.w[SP_IDX];
        wdat = q.hi;
        n.w[SP_IDX] = q.w[SP_IDX] + SP_STEP; // RQ7
        jump = 1'b1;
        jt = q.tgt;
        n.st = ST_RUN;
        if (q.intr) begin
          n.cpu_prio = q.nprio; // RQ16
          n.ack.valid = 1'b1;
          n.ack.id = q.aid;
        end
      end
      ST_POP: begin
        // Low return word, then resume
        do_rd = 1'b1;
        n.w[SP_IDX] = sp_dn; // RQ7
        jump = 1'b1;
        jt = {q.hi[6:0], rdat};
        n.st = ST_RUN;
        if (q.retfie) begin
          n.cpu_prio = q.hi[HI_PRIO +: PRW];
        end
      end
      ST_RUN: begin
        if (!q.ex_valid) begin
          hold = 1'b1;
        end else if (take) begin
          // Vectored entry; current instruction is re-run on return
          do_wr = 1'b1;
          ma_wr = q.w[SP_IDX];
          wdat = q.ex_pc[DW-1:0];
          n.w[SP_IDX] = q.w[SP_IDX] + SP_STEP; // RQ7
          n.hi = {q.cpu_prio, 6'h00, q.ex_pc[PCW-1:DW]};
          n.tgt = IVT_BASE + {16'h0000, sel.id}; // RQ15
          n.intr = 1'b1;
          n.nprio = sel.prio;
          n.aid = sel.id;
          n.dcnt = '0;
          n.ph = 1'b0;
          n.st = ST_PUSH;
          hold = 1'b1;
        end else begin
          unique case (op)
            OP_NOP: begin
            end
            OP_ALU: n.w[rd] = alu(i_pm_data[F_RX +: 4], q.w[rs], q.w[rt]); // RQ1 RQ6
            OP_LIT: n.w[rx] = i_pm_data[DW-1:0]; // RQ9
            OP_LD, OP_LDD: begin
              do_rd = 1'b1;
              n.w[op == OP_LD ? rd : rx] = rdat; // RQ6
            end
            OP_ST: do_wr = 1'b1;
            OP_TRI: begin
              // Memory read, register read and write in one cycle
              do_rd = 1'b1;
              do_wr = 1'b1;
              ma_wr = q.w[rd];
              wdat = rdat + q.w[rt]; // RQ10
            end
            OP_MUL: begin
              {n.w[{rd[3:1], 1'b1}], n.w[{rd[3:1], 1'b0}]} =
                mul17(q.w[rs], q.w[rt], i_pm_data[F_MODE +: 2],
                      i_pm_data[F_BYTE]); // RQ11 RQ12
            end
            OP_DIV: begin
              hold = (q.dcnt != DIV_LAST); // RQ14
              n.dcnt = hold ? q.dcnt + 5'h01 : 5'h00;
              if (q.dcnt == 5'h00) begin
                if (i_pm_data[F_LONG]) begin
                  num = {q.w[1], q.w[0]};
                end else begin
                  num = {{DW{i_pm_data[F_SGN] & q.w[0][DW-1]}}, q.w[0]};
                end
                nneg = i_pm_data[F_SGN] & num[2*DW-1];
                dneg = i_pm_data[F_SGN] & q.w[rt][DW-1];
                an = nneg ? -num : num;
                ad = dneg ? -q.w[rt] : q.w[rt];
                n.drem = {1'b0, an[2*DW-1:DW]};
                n.dq = an[DW-1:0];
                n.dd = ad;
                n.dneg_q = nneg ^ dneg;
                n.dneg_r = nneg;
              end else if (q.dcnt <= DIV_STEP_LAST) begin
                {n.drem, n.dq} = dstep(q.drem, q.dq, q.dd); // RQ13
              end else if (q.dcnt == DIV_FIX) begin
                if (q.drem[DW]) begin
                  n.drem = q.drem + {1'b0, q.dd}; // RQ13
                end
              end else begin
                n.w[0] = q.dneg_q ? -q.dq : q.dq;
                n.w[1] = q.dneg_r ? -q.drem[DW-1:0] : q.drem[DW-1:0];
              end
            end
            OP_REP: begin
              n.rep_cnt = i_pm_data[F_RCNT_W-1:0]; // RQ5
              n.rep_on = 1'b1;
              n.rep_pc = ret_pc;
            end
            OP_BRA, OP_BZ: begin
              if (op == OP_BRA || q.w[rx] == 16'h0000) begin
                jump = 1'b1;
                jt = q.ex_pc + {{7{i_pm_data[DW-1]}}, i_pm_data[DW-1:0]}; // RQ9
              end
            end
            OP_CALL: begin
              // First return word; the jump follows next cycle
              do_wr = 1'b1;
              ma_wr = q.w[SP_IDX];
              wdat = ret_pc[DW-1:0];
              n.w[SP_IDX] = q.w[SP_IDX] + SP_STEP; // RQ7
              n.hi = {q.cpu_prio, 6'h00, ret_pc[PCW-1:DW]};
              n.tgt = i_pm_data[PCW-1:0];
              n.intr = 1'b0;
              n.st = ST_PUSH;
              hold = 1'b1; // RQ4
            end
            OP_RET, OP_RETI: begin
              do_rd = 1'b1;
              n.w[SP_IDX] = sp_dn; // RQ7
              n.hi = rdat;
              n.retfie = (op == OP_RETI);
              n.st = ST_POP;
              hold = 1'b1; // RQ4
            end
            OP_DMOV: begin
              // Two words over two cycles
              do_wr = 1'b1;
              ma_wr = q.ph ? q.w[rs] + SP_STEP : q.w[rs];
              wdat = q.ph ? q.w[{rt[3:1], 1'b1}] : q.w[{rt[3:1], 1'b0}];
              n.ph = ~q.ph;
              hold = ~q.ph; // RQ4
            end
          endcase
          // Repeat: same word re-executed with no fetch gap
          if (!hold && q.rep_on && q.ex_pc == q.rep_pc) begin
            if (q.rep_cnt != '0) begin
              n.rep_cnt = q.rep_cnt - 14'h0001; // RQ5
              hold = 1'b1;
            end else begin
              n.rep_on = 1'b0;
            end
          end
        end
      end
      default: n.st = ST_RUN;
    endcase
    // Fetch: target, held word, or prefetch of the next word
    if (jump) begin
      pm_addr = jt;
      n.ex_pc = jt; // RQ2
    end else if (hold) begin
      pm_addr = q.ex_pc;
    end else begin
      pm_addr = ret_pc; // RQ3
      n.ex_pc = ret_pc; // RQ2
    end
    // Core-mapped writes stay inside; others go to memory
    if (do_wr && ma_wr == SR_ADDR) begin
      n.cpu_prio = wdat[PRW-1:0]; // RQ17
    end else if (do_wr && ma_wr < WREG_TOP) begin
      n.w[ma_wr[4:1]] = wdat; // RQ17
    end
    dm = '0;
    dm.rd_en = do_rd && !is_core(ma_rd);
    dm.rd_addr = ma_rd;
    dm.rd_ext = ma_rd[EXT_BIT]; // RQ8
    dm.wr_en = do_wr && !is_core(ma_wr);
    dm.wr_addr = ma_wr;
    dm.wr_data = wdat;
    dm.wr_ext = ma_wr[EXT_BIT]; // RQ8
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      q <= '0;
      q.ex_pc <= RESET_VEC;
    end else begin
      q <= n;
    end
  end

  // Outputs
  assign o_pm_addr = pm_addr;
  assign o_dm = dm;
  assign o_ack = q.ack;
  assign o_cpu_prio = q.cpu_prio;
  assign o_program_counter = q.ex_pc;

  // ****************************************************
  // Assertions
  // ****************************************************
  a_prefetch_seq: assert property (@(posedge i_ref_clk) // RQ3
    disable iff (!i_resetn) exec && op == OP_NOP && !q.rep_on
    |-> o_pm_addr == q.ex_pc + 23'h000001 ##1 q.ex_pc == $past(o_pm_addr))
    else $error("prefetch not sequential");
  a_alu_single: assert property (@(posedge i_ref_clk) // RQ4
    disable iff (!i_resetn)
    exec && op == OP_ALU && i_pm_data[F_RX +: 4] == ALU_ADD && rd != rs
    && rd != rt |=> q.w[$past(rd)] == $past(q.w[rs]) + $past(q.w[rt]))
    else $error("add did not finish in one cycle");
  a_mul_word: assert property (@(posedge i_ref_clk) // RQ12
    disable iff (!i_resetn)
    exec && op == OP_MUL && i_pm_data[F_MODE +: 2] == MUL_UU
    && !i_pm_data[F_BYTE] |=> {q.w[{$past(rd[3:1]), 1'b1}],
    q.w[{$past(rd[3:1]), 1'b0}]} == $past(q.w[rs]) * $past(q.w[rt]))
    else $error("unsigned multiply wrong");
  a_div_count: assert property (@(posedge i_ref_clk) // RQ14
    disable iff (!i_resetn)
    q.dcnt == DIV_LAST |-> $past(q.dcnt, 18) == 5'h00)
    else $error("divide length is not 19 cycles");
  a_div_done: assert property (@(posedge i_ref_clk) // RQ14
    disable iff (!i_resetn) exec && op == OP_DIV && q.dcnt == DIV_LAST
    |=> q.dcnt == 5'h00 && q.ex_pc == $past(q.ex_pc) + 23'h000001)
    else $error("divide did not retire");
  a_irq_vector: assert property (@(posedge i_ref_clk) // RQ15
    disable iff (!i_resetn) take
    |=> q.st == ST_PUSH ##1 q.ex_pc == IVT_BASE + {16'h0000, $past(sel.id, 2)}
    && o_ack.valid && o_ack.id == $past(sel.id, 2))
    else $error("vectored entry wrong");
  a_irq_prio: assert property (@(posedge i_ref_clk) // RQ18
    disable iff (!i_resetn) take && i_trap == '0
    |-> i_irq_prio[(sel.id - NTRAP)*PRW +: PRW] > q.cpu_prio
    && i_irq_prio[(sel.id - NTRAP)*PRW +: PRW] != 3'h0)
    else $error("masked source taken");
  a_stack_push: assert property (@(posedge i_ref_clk) // RQ7
    disable iff (!i_resetn) take
    |-> ##2 q.w[SP_IDX] == $past(q.w[SP_IDX], 2) + 16'h0004)
    else $error("stack pointer not advanced by two words");
  a_rep_hold: assert property (@(posedge i_ref_clk) // RQ5
    disable iff (!i_resetn) exec && q.rep_on && q.ex_pc == q.rep_pc
    && q.rep_cnt != '0 && (op == OP_NOP || op == OP_ALU)
    |=> q.ex_pc == $past(q.ex_pc) && q.rep_cnt == $past(q.rep_cnt) - 14'h0001)
    else $error("repeat did not hold the word");
  a_tri_op: assert property (@(posedge i_ref_clk) // RQ10
    disable iff (!i_resetn) exec && op == OP_TRI && !is_core(q.w[rs])
    && !is_core(q.w[rd]) |-> o_dm.rd_en && o_dm.wr_en
    && o_dm.wr_data == i_dm_rdata + q.w[rt])
    else $error("three-operand access wrong");
  a_ext_window: assert property (@(posedge i_ref_clk) // RQ8
    disable iff (!i_resetn)
    o_dm.wr_en |-> o_dm.wr_ext == (o_dm.wr_addr >= 16'h8000))
    else $error("window flag wrong");

endmodule
`default_nettype wire

/* dv/cpd_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cpd_mem_model
  import cpd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [PCW-1:0] i_pm_addr,
  output logic [IW-1:0] o_pm_data,
  input wire cpd_dm_req_t i_dm,
  output logic [DW-1:0] o_dm_rdata,
  input wire logic [NIRQ-1:0] i_raise,
  input wire cpd_ack_t i_ack,
  output logic [NIRQ-1:0] o_irq_req,
  output logic o_ext_bad
);
  logic [IW-1:0] rom [0:255];
  logic [DW-1:0] mem [0:32767];
  logic [DW-1:0] last_q;
  logic [NIRQ-1:0] clr;
  // Synchronous program store, word shows one cycle late
  always @(posedge i_ref_clk) begin
    o_pm_data <= rom[i_pm_addr[7:0]];
  end
  // Idle read bus shows the inverse of the last word, never a copy
  assign o_dm_rdata = i_dm.rd_en ? mem[i_dm.rd_addr[15:1]] : ~last_q;
  // Acked source drops its own request
  always_comb begin
    clr = '0;
    if (i_ack.valid && i_ack.id >= 7'h08) begin
      clr[i_ack.id - 7'h08] = 1'b1;
    end
  end
  // Word writes, window flag watch, request levels
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      last_q <= 16'hA5A5;
      o_ext_bad <= 1'b0;
      o_irq_req <= '0;
    end else begin
      if (i_dm.rd_en) last_q <= o_dm_rdata;
      if (i_dm.wr_en) mem[i_dm.wr_addr[15:1]] <= i_dm.wr_data;
      if (i_dm.wr_en && i_dm.wr_ext !== i_dm.wr_addr[15]) begin
        o_ext_bad <= 1'b1;
      end
      if (i_dm.rd_en && i_dm.rd_ext !== i_dm.rd_addr[15]) begin
        o_ext_bad <= 1'b1;
      end
      o_irq_req <= (o_irq_req | i_raise) & ~clr;
    end
  end
endmodule
`default_nettype wire

/* dv/cpu_core_datapath_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module cpu_core_datapath_tb
  import cpd_pkg::*;
;
  logic i_ref_clk;
  logic i_resetn;
  logic [PCW-1:0] pm_addr;
  logic [IW-1:0] pm_data;
  cpd_dm_req_t dm;
  logic [DW-1:0] dm_rdata;
  logic [NIRQ-1:0] i_raise;
  logic [NIRQ-1:0] irq_req;
  logic [NIRQ*PRW-1:0] i_irq_prio;
  logic [NTRAP-1:0] i_trap;
  cpd_ack_t ack;
  logic [PRW-1:0] cpu_prio;
  logic [PCW-1:0] pc;
  logic ext_bad;
  int bad_count;
  int n_tests;
  int n_ack;
  logic [IDW-1:0] ack_id;

  cpd_core DUT (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .o_pm_addr(pm_addr), .i_pm_data(pm_data), .o_dm(dm),
    .i_dm_rdata(dm_rdata), .i_irq_req(irq_req), .i_irq_prio(i_irq_prio),
    .i_trap(i_trap), .o_ack(ack), .o_cpu_prio(cpu_prio),
    .o_program_counter(pc));
  cpd_mem_model pm (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_pm_addr(pm_addr), .o_pm_data(pm_data), .i_dm(dm),
    .o_dm_rdata(dm_rdata), .i_raise(i_raise), .i_ack(ack),
    .o_irq_req(irq_req), .o_ext_bad(ext_bad));

  // ****
  // Clock, ack monitor, helpers
  // ****
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  always @(negedge i_ref_clk) begin
    if (ack.valid === 1'b1) begin
      n_ack++;
      ack_id = ack.id;
    end
  end
  function automatic logic [23:0] lit(input logic [3:0] r,
      input logic [15:0] v);
    return {OP_LIT, r, v};
  endfunction
  function automatic logic [23:0] ins(input logic [3:0] op,
      input logic [3:0] x, input logic [3:0] rd, input logic [3:0] rs,
      input logic [3:0] rt);
    return {op, x, 4'h0, rd, rs, rt};
  endfunction
  function automatic logic [15:0] dmw(input logic [15:0] a);
    return pm.mem[a[15:1]];
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic run_prog(input logic [23:0] prog [$], input int n);
    i_resetn <= 1'b0;
    for (int i = 0; i < 256; i++) pm.rom[i] = 24'h000000;
    foreach (prog[i]) pm.rom[i] = prog[i];
    n_ack = 0;
    repeat (8) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    repeat (n) @(posedge i_ref_clk);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    run_prog('{24'h000000}, 0);
    check(pc, 32'h0);
    check(cpu_prio, 32'h0);
    check(ack, 32'h0);
    #1 check(pm_addr, 32'h0);
    @(posedge i_ref_clk);
    #1 check(pm_addr, 32'h1);
    check(pc, 32'h0);
    @(posedge i_ref_clk);
    $display("test reset done");
  endtask
  task automatic t_alu_tri();
    run_prog('{lit(1, 16'h0320), lit(2, 16'h0322), lit(3, 16'h0005),
      lit(4, 16'h1234), ins(OP_ST, 0, 0, 1, 4), ins(OP_TRI, 0, 2, 1, 3),
      ins(OP_ALU, ALU_SUB, 5, 4, 3), lit(6, 16'h8004),
      ins(OP_ST, 0, 0, 6, 5)}, 30);
    check(dmw(16'h0320), 32'h1234);
    check(dmw(16'h0322), 32'h1239);
    check(dmw(16'h8004), 32'h122F);
    check(ext_bad, 32'h0);
    $display("test alu_tri done");
  endtask
  task automatic t_mul();
    run_prog('{lit(4, 16'hFFFD), lit(5, 16'h0005),
      ins(OP_MUL, 4'h2, 8, 4, 5), ins(OP_MUL, 4'h0, 10, 4, 5),
      lit(2, 16'h0330), lit(3, 16'h0332), ins(OP_ST, 0, 0, 2, 8),
      ins(OP_ST, 0, 0, 3, 9), lit(2, 16'h0334),
      ins(OP_ST, 0, 0, 2, 11)}, 30);
    check(dmw(16'h0330), 32'hFFF1);
    check(dmw(16'h0332), 32'hFFFF);
    check(dmw(16'h0334), 32'h0004);
    $display("test mul done");
  endtask
  task automatic t_div();
    int cyc;
    cyc = 0;
    run_prog('{lit(0, 16'h0064), lit(7, 16'h0007), lit(2, 16'h0340),
      lit(3, 16'h0342), ins(OP_DIV, 0, 0, 0, 7), ins(OP_ST, 0, 0, 2, 0),
      ins(OP_ST, 0, 0, 3, 1)}, 0);
    repeat (60) begin
      @(negedge i_ref_clk);
      if (pc === 23'h000004) cyc++;
    end
    @(posedge i_ref_clk);
    check(cyc, 32'd19);
    check(dmw(16'h0340), 32'h000E);
    check(dmw(16'h0342), 32'h0002);
    $display("test div done");
  endtask
  task automatic t_irq();
    logic [23:0] prog [$];
    prog = '{lit(15, 16'h0100), lit(0, 16'h0200)};
    repeat (13) prog.push_back(24'h000000);
    prog.push_back(ins(OP_ST, 0, 0, 0, 15));
    i_irq_prio[9 +: 3] <= 3'h5;
    i_irq_prio[12 +: 3] <= 3'h0;
    run_prog(prog, 4);
    i_raise <= {{(NIRQ-5){1'b0}}, 5'h18};
    @(posedge i_ref_clk);
    i_raise <= '0;
    repeat (30) @(posedge i_ref_clk);
    check(n_ack, 32'd1);
    check(ack_id, 32'h0B);
    check(cpu_prio, 32'h5);
    check(dmw(16'h0102), 32'h0000);
    check(dmw(16'h0200), 32'h0104);
    check(irq_req[4:3], 32'h2);
    // Trap 2 held for one cycle; taken above the current level
    i_trap <= 8'h04;
    @(posedge i_ref_clk);
    i_trap <= '0;
    repeat (20) @(posedge i_ref_clk);
    check(n_ack, 32'd2);
    check(ack_id, 32'h02);
    check(cpu_prio, 32'h7);
    check(dmw(16'h0106), 32'hA000);
    check(dmw(16'h0200), 32'h0108);
    $display("test irq done");
  endtask
  task automatic t_flow();
    run_prog('{lit(15, 16'h0100), lit(1, 16'h0000), lit(2, 16'h0005),
      ins(OP_REP, 0, 0, 0, 3), ins(OP_ALU, ALU_ADD, 1, 1, 2),
      {OP_CALL, 20'h00010}, lit(3, 16'h0350), ins(OP_DMOV, 0, 0, 3, 0),
      {OP_LDD, 4'h5, 16'h0352}, {OP_BZ, 4'h6, 16'h0002},
      lit(5, 16'hDEAD), lit(3, 16'h0354), ins(OP_ST, 0, 0, 3, 5),
      {OP_BRA, 20'h00000}, 24'h000000, 24'h000000, lit(0, 16'h00AB),
      ins(OP_RET, 0, 0, 0, 0)}, 40);
    check(dmw(16'h0350), 32'h00AB);
    check(dmw(16'h0352), 32'h0014);
    check(dmw(16'h0354), 32'h0014);
    check(dmw(16'h0100), 32'h0006);
    check(pc, 32'h00000D);
    $display("test flow done");
  endtask

  // ****
  // Run control
  // ****
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    i_resetn = 1'b0;
    i_raise = '0;
    i_irq_prio = '0;
    i_trap = '0;
    bad_count = 0;
    n_tests = 0;
    n_ack = 0;
    ack_id = '0;
    t_reset();
    t_alu_tri();
    t_mul();
    t_div();
    t_flow();
    t_irq();
    report_and_stop();
  end
endmodule
`default_nettype wire
